// ---- src/ebmf_defines.vh ----
// Offsets, field positions, codes and reset values of the block memory.
`ifndef EBMF_DEFINES_VH
`define EBMF_DEFINES_VH

`define EBMF_OFF_CTRL      8'h00
`define EBMF_OFF_AF_LEVEL  8'h04
`define EBMF_OFF_AE_LEVEL  8'h08
`define EBMF_OFF_STATUS    8'h0c
`define EBMF_OFF_INIT_ADDR 8'h10
`define EBMF_OFF_INIT_LO   8'h14
`define EBMF_OFF_INIT_HI   8'h18

`define EBMF_CTRL_MODE_LSB   0
`define EBMF_CTRL_WA_LSB     3
`define EBMF_CTRL_WB_LSB     6
`define EBMF_CTRL_ECC_BIT    9
`define EBMF_CTRL_OREG_BIT   10
`define EBMF_CTRL_ASYNC_BIT  11
`define EBMF_CTRL_WIDTH      12

`define EBMF_ST_EMPTY_BIT    0
`define EBMF_ST_AEMPTY_BIT   1
`define EBMF_ST_FULL_BIT     2
`define EBMF_ST_AFULL_BIT    3
`define EBMF_ST_SERR_BIT     4
`define EBMF_ST_DERR_BIT     5
`define EBMF_ST_COUNT_LSB    16

`define EBMF_CTRL_RST     12'h000
`define EBMF_AF_RST       15'h3f00
`define EBMF_AE_RST       15'h0010

`define EBMF_MODE_SP      3'h0
`define EBMF_MODE_TDP     3'h1
`define EBMF_MODE_PDP     3'h2
`define EBMF_MODE_ROM     3'h3
`define EBMF_MODE_FIFO    3'h4

`define EBMF_W1           3'h0
`define EBMF_W2           3'h1
`define EBMF_W4           3'h2
`define EBMF_W9           3'h3
`define EBMF_W18          3'h4
`define EBMF_W36          3'h5

`define EBMF_ROWS         512
`define EBMF_ROW_BITS     36
`define EBMF_CHK_BITS     7
`define EBMF_CODE_LEN     38

`endif

// ---- src/ebmf_core.v ----
// Embedded 18 kb block memory with width matching, ECC and FIFO control.
`include "ebmf_defines.vh"

module ebmf_core (
	input  wire        clock,
	input  wire        reset,
	input  wire        global_reset_n,
	input  wire [7:0]  paddr,
	input  wire        psel,
	input  wire        penable,
	input  wire        pwrite,
	input  wire [31:0] pwdata,
	output wire [31:0] prdata,
	output wire        pready,
	output wire        pslverr,
	input  wire        port_a_ce,
	input  wire        port_a_we,
	input  wire [13:0] port_a_addr,
	input  wire [35:0] port_a_wdata,
	input  wire [3:0]  port_a_byte_en,
	input  wire        port_a_output_reset,
	output wire [35:0] port_a_rdata,
	output wire        port_a_single_err,
	output wire        port_a_double_err,
	input  wire        port_b_ce,
	input  wire        port_b_we,
	input  wire [13:0] port_b_addr,
	input  wire [35:0] port_b_wdata,
	input  wire [3:0]  port_b_byte_en,
	input  wire        port_b_output_reset,
	output wire [35:0] port_b_rdata,
	output wire        port_b_single_err,
	output wire        port_b_double_err,
	output wire        fifo_full,
	output wire        fifo_almost_full,
	output wire        fifo_empty,
	output wire        fifo_almost_empty
);

	reg  [35:0] mem [0:`EBMF_ROWS-1];
	reg  [6:0]  chk [0:`EBMF_ROWS-1];

	reg  [11:0] ctrl_r;
	reg  [14:0] af_level_r;
	reg  [14:0] ae_level_r;
	reg         serr_r;
	reg         derr_r;
	reg  [8:0]  init_addr_r;
	reg  [31:0] init_lo_r;
	reg  [31:0] prdata_r;
	reg         gn_s1_r;
	reg         gn_s2_r;
	reg  [14:0] wptr_r;
	reg  [14:0] rptr_r;

	reg         a_rd_r;
	reg         a_wr_r;
	reg  [13:0] a_addr_r;
	reg  [35:0] a_wdata_r;
	reg  [3:0]  a_be_r;
	reg  [35:0] a_lat_r;
	reg  [35:0] a_pip_r;
	reg         a_se_r;
	reg         a_de_r;
	reg         a_sep_r;
	reg         a_dep_r;
	reg         b_rd_r;
	reg         b_wr_r;
	reg  [13:0] b_addr_r;
	reg  [35:0] b_wdata_r;
	reg  [3:0]  b_be_r;
	reg  [35:0] b_lat_r;
	reg  [35:0] b_pip_r;
	reg         b_se_r;
	reg         b_de_r;
	reg         b_sep_r;
	reg         b_dep_r;

	wire [2:0]  mode = ctrl_r[`EBMF_CTRL_MODE_LSB +: 3];
	wire        ecc_on = ctrl_r[`EBMF_CTRL_ECC_BIT] && mode != `EBMF_MODE_FIFO
		&& mode != `EBMF_MODE_ROM;
	wire        oreg_on = ctrl_r[`EBMF_CTRL_OREG_BIT];
	wire        async_on = ctrl_r[`EBMF_CTRL_ASYNC_BIT];
	wire [2:0]  wa_cfg = ctrl_r[`EBMF_CTRL_WA_LSB +: 3];
	wire [2:0]  wb_cfg = ctrl_r[`EBMF_CTRL_WB_LSB +: 3];
	wire [2:0]  wa = (wa_cfg > `EBMF_W36) ? `EBMF_W36 :
		(mode == `EBMF_MODE_TDP && wa_cfg == `EBMF_W36) ? `EBMF_W18 :
		wa_cfg;
	wire [2:0]  wb_lim = (wb_cfg > `EBMF_W36) ? `EBMF_W36 :
		(mode == `EBMF_MODE_TDP && wb_cfg == `EBMF_W36) ? `EBMF_W18 :
		wb_cfg;
	wire [2:0]  wb = (mode == `EBMF_MODE_FIFO) ? wa : wb_lim;

	wire        grst = ~gn_s2_r | reset;
	wire        a_rst = port_a_output_reset | grst;
	wire        b_rst = port_b_output_reset | grst;

	wire [14:0] count = wptr_r - rptr_r;
	wire [14:0] depth = 15'h4000 >> wa;
	wire        is_fifo = (mode == `EBMF_MODE_FIFO);
	wire        full_w = count >= depth;
	wire        empty_w = (count == 15'h0000);

	wire        apb_wr = psel & penable & pwrite;
	wire        hit = (paddr == `EBMF_OFF_CTRL) || (paddr == `EBMF_OFF_AF_LEVEL)
		|| (paddr == `EBMF_OFF_AE_LEVEL) || (paddr == `EBMF_OFF_STATUS)
		|| (paddr == `EBMF_OFF_INIT_ADDR) || (paddr == `EBMF_OFF_INIT_LO)
		|| (paddr == `EBMF_OFF_INIT_HI);
	wire        init_wr = apb_wr && paddr == `EBMF_OFF_INIT_HI;

	function [8:0] row_of (input [13:0] a, input [2:0] w);
		begin
			case (w)
				`EBMF_W1:  row_of = a[13:5];
				`EBMF_W2:  row_of = a[12:4];
				`EBMF_W4:  row_of = a[11:3];
				`EBMF_W9:  row_of = a[10:2];
				`EBMF_W18: row_of = a[9:1];
				default:   row_of = a[8:0];
			endcase
		end
	endfunction

	// Narrow widths pack the 32 data bits of a row; wide ones use 9-bit lanes.
	function [35:0] get_field (input [35:0] r, input [13:0] a, input [2:0] w);
		begin
			case (w)
				`EBMF_W1:  get_field = {35'h0, r[a[4:0]]};
				`EBMF_W2:  get_field = {34'h0, r[{a[3:0], 1'b0} +: 2]};
				`EBMF_W4:  get_field = {32'h0, r[{a[2:0], 2'b00} +: 4]};
				`EBMF_W9:  get_field = {27'h0, r[a[1:0] * 9 +: 9]};
				`EBMF_W18: get_field = {18'h0, r[a[0] * 18 +: 18]};
				default:   get_field = r;
			endcase
		end
	endfunction

	function [35:0] put_field (input [35:0] r, input [13:0] a, input [2:0] w,
		input [35:0] d, input [3:0] be);
		integer k;
		begin
			put_field = r;
			case (w)
				`EBMF_W1:  put_field[a[4:0]] = d[0];
				`EBMF_W2:  put_field[{a[3:0], 1'b0} +: 2] = d[1:0];
				`EBMF_W4:  put_field[{a[2:0], 2'b00} +: 4] = d[3:0];
				`EBMF_W9:  put_field[a[1:0] * 9 +: 9] = d[8:0];
				`EBMF_W18: begin
					if (be[0])
						put_field[a[0] * 18 +: 9] = d[8:0];
					if (be[1])
						put_field[a[0] * 18 + 9 +: 9] = d[17:9];
				end
				default: begin
					for (k = 0; k < 4; k = k + 1) begin
						if (be[k])
							put_field[k * 9 +: 9] = d[k * 9 +: 9];
					end
				end
			endcase
		end
	endfunction

	// Hamming code over positions 1..38 plus an overall parity bit.
	function [6:0] ecc_gen (input [31:0] d);
		integer p;
		integer j;
		integer k;
		reg [6:0] c;
		begin
			c = 7'h00;
			j = 0;
			for (p = 1; p <= `EBMF_CODE_LEN; p = p + 1) begin
				if ((p & (p - 1)) != 0) begin
					for (k = 0; k < 6; k = k + 1) begin
						if (p[k])
							c[k] = c[k] ^ d[j];
					end
					j = j + 1;
				end
			end
			c[6] = ^{d, c[5:0]};
			ecc_gen = c;
		end
	endfunction

	// Returns double flag, single flag and the corrected word.
	function [33:0] ecc_check (input [31:0] d, input [6:0] c);
		integer p;
		integer j;
		reg [5:0]  s;
		reg        odd;
		reg [31:0] f;
		reg [6:0]  g;
		begin
			g = ecc_gen(d);
			s = g[5:0] ^ c[5:0];
			odd = ^{d, c};
			f = d;
			j = 0;
			for (p = 1; p <= `EBMF_CODE_LEN; p = p + 1) begin
				if ((p & (p - 1)) != 0) begin
					if (odd && s == p[5:0])
						f[j] = ~f[j];
					j = j + 1;
				end
			end
			ecc_check = {~odd && s != 6'h00, odd, f};
		end
	endfunction

	wire [8:0]  a_row = row_of(a_addr_r, ecc_on ? `EBMF_W36 : wa);
	wire [8:0]  b_row = row_of(b_addr_r, ecc_on ? `EBMF_W36 : wb);
	wire [33:0] a_ecc = ecc_check(mem[a_row][31:0], chk[a_row]);
	wire [33:0] b_ecc = ecc_check(mem[b_row][31:0], chk[b_row]);
	wire [35:0] a_rval = ecc_on ? {4'h0, a_ecc[31:0]} :
		get_field(mem[a_row], a_addr_r, wa);
	wire [35:0] b_rval = ecc_on ? {4'h0, b_ecc[31:0]} :
		get_field(mem[b_row], b_addr_r, wb);

	wire a_wr_ok = port_a_ce && port_a_we && mode != `EBMF_MODE_ROM
		&& !(is_fifo && full_w);
	wire a_rd_ok = port_a_ce && !port_a_we && !is_fifo
		&& mode != `EBMF_MODE_PDP;
	wire b_on = mode != `EBMF_MODE_SP;
	wire b_wr_ok = b_on && port_b_ce && port_b_we && mode == `EBMF_MODE_TDP;
	wire b_rd_ok = b_on && port_b_ce && (is_fifo ? !empty_w :
		(!port_b_we || mode != `EBMF_MODE_TDP));

	always @(posedge clock) begin
		gn_s1_r <= global_reset_n;
		gn_s2_r <= gn_s1_r;
	end

	// Register file over APB.
	always @(posedge clock) begin
		if (reset) begin
			ctrl_r <= `EBMF_CTRL_RST;
			af_level_r <= `EBMF_AF_RST;
			ae_level_r <= `EBMF_AE_RST;
			init_addr_r <= 9'h000;
			init_lo_r <= 32'h0;
			serr_r <= 1'b0;
			derr_r <= 1'b0;
			prdata_r <= 32'h0;
		end else begin
			if (apb_wr && paddr == `EBMF_OFF_CTRL)
				ctrl_r <= pwdata[`EBMF_CTRL_WIDTH-1:0];
			if (apb_wr && paddr == `EBMF_OFF_AF_LEVEL)
				af_level_r <= pwdata[14:0];
			if (apb_wr && paddr == `EBMF_OFF_AE_LEVEL)
				ae_level_r <= pwdata[14:0];
			if (apb_wr && paddr == `EBMF_OFF_INIT_ADDR)
				init_addr_r <= pwdata[8:0];
			else if (init_wr)
				init_addr_r <= init_addr_r + 9'h001;
			if (apb_wr && paddr == `EBMF_OFF_INIT_LO)
				init_lo_r <= pwdata;
			if (a_se_r || b_se_r)
				serr_r <= 1'b1;
			else if (apb_wr && paddr == `EBMF_OFF_STATUS
				&& pwdata[`EBMF_ST_SERR_BIT])
				serr_r <= 1'b0;
			if (a_de_r || b_de_r)
				derr_r <= 1'b1;
			else if (apb_wr && paddr == `EBMF_OFF_STATUS
				&& pwdata[`EBMF_ST_DERR_BIT])
				derr_r <= 1'b0;
			if (psel && !penable) begin
				case (paddr)
					`EBMF_OFF_CTRL:      prdata_r <= {20'h0, ctrl_r};
					`EBMF_OFF_AF_LEVEL:  prdata_r <= {17'h0, af_level_r};
					`EBMF_OFF_AE_LEVEL:  prdata_r <= {17'h0, ae_level_r};
					`EBMF_OFF_STATUS:    prdata_r <= {1'b0, count, 10'h0,
						derr_r, serr_r, fifo_almost_full, fifo_full,
						fifo_almost_empty, fifo_empty};
					`EBMF_OFF_INIT_ADDR: prdata_r <= {23'h0, init_addr_r};
					`EBMF_OFF_INIT_LO:   prdata_r <= init_lo_r;
					default:             prdata_r <= 32'h0;
				endcase
			end
		end
	end

	// Input registers and FIFO counters.
	always @(posedge clock) begin
		if (reset) begin
			a_rd_r <= 1'b0;
			a_wr_r <= 1'b0;
			b_rd_r <= 1'b0;
			b_wr_r <= 1'b0;
			a_addr_r <= 14'h0000;
			b_addr_r <= 14'h0000;
			a_wdata_r <= 36'h0;
			b_wdata_r <= 36'h0;
			a_be_r <= 4'h0;
			b_be_r <= 4'h0;
			wptr_r <= 15'h0000;
			rptr_r <= 15'h0000;
		end else begin
			a_rd_r <= a_rd_ok;
			a_wr_r <= a_wr_ok;
			a_addr_r <= is_fifo ? wptr_r[13:0] : port_a_addr;
			a_wdata_r <= port_a_wdata;
			a_be_r <= (wa >= `EBMF_W18) ? port_a_byte_en : 4'hf;
			b_rd_r <= b_rd_ok;
			b_wr_r <= b_wr_ok;
			b_addr_r <= is_fifo ? rptr_r[13:0] : port_b_addr;
			b_wdata_r <= port_b_wdata;
			b_be_r <= (wb >= `EBMF_W18) ? port_b_byte_en : 4'hf;
			if (!is_fifo) begin
				wptr_r <= 15'h0000;
				rptr_r <= 15'h0000;
			end else begin
				if (a_wr_ok)
					wptr_r <= wptr_r + 15'h0001;
				if (b_rd_ok)
					rptr_r <= rptr_r + 15'h0001;
			end
		end
	end

	// Array writes: a preload shuts out both ports, else port A, then port B on top.
	always @(posedge clock) begin
		if (init_wr) begin
			mem[init_addr_r] <= {pwdata[3:0], init_lo_r};
			chk[init_addr_r] <= ecc_gen(init_lo_r);
		end else begin
			if (a_wr_r && ecc_on) begin
				mem[a_row] <= {4'h0, a_wdata_r[31:0]};
				chk[a_row] <= ecc_gen(a_wdata_r[31:0]);
			end else if (a_wr_r) begin
				mem[a_row] <= put_field(mem[a_row], a_addr_r, wa,
					a_wdata_r, a_be_r);
			end
			if (b_wr_r && ecc_on) begin
				mem[b_row] <= {4'h0, b_wdata_r[31:0]};
				chk[b_row] <= ecc_gen(b_wdata_r[31:0]);
			end else if (b_wr_r) begin
				mem[b_row] <= put_field(mem[b_row], b_addr_r, wb,
					b_wdata_r, b_be_r);
			end
		end
	end

	// Output latches and pipeline registers with their resets.
	always @(posedge clock) begin
		if (a_rst) begin
			a_lat_r <= 36'h0;
			a_pip_r <= 36'h0;
			a_se_r <= 1'b0;
			a_de_r <= 1'b0;
			a_sep_r <= 1'b0;
			a_dep_r <= 1'b0;
		end else begin
			if (a_rd_r) begin
				a_lat_r <= a_rval;
				a_se_r <= ecc_on & a_ecc[32];
				a_de_r <= ecc_on & a_ecc[33];
			end else begin
				a_se_r <= 1'b0;
				a_de_r <= 1'b0;
			end
			a_pip_r <= a_lat_r;
			a_sep_r <= a_se_r;
			a_dep_r <= a_de_r;
		end
		if (b_rst) begin
			b_lat_r <= 36'h0;
			b_pip_r <= 36'h0;
			b_se_r <= 1'b0;
			b_de_r <= 1'b0;
			b_sep_r <= 1'b0;
			b_dep_r <= 1'b0;
		end else begin
			if (b_rd_r) begin
				b_lat_r <= b_rval;
				b_se_r <= ecc_on & b_ecc[32];
				b_de_r <= ecc_on & b_ecc[33];
			end else begin
				b_se_r <= 1'b0;
				b_de_r <= 1'b0;
			end
			b_pip_r <= b_lat_r;
			b_sep_r <= b_se_r;
			b_dep_r <= b_de_r;
		end
	end

	// Asynchronous mode forces the outputs low at once while a reset stands.
	wire a_force = async_on & a_rst;
	wire b_force = async_on & b_rst;

	assign port_a_rdata = a_force ? 36'h0 : (oreg_on ? a_pip_r : a_lat_r);
	assign port_b_rdata = b_force ? 36'h0 : (oreg_on ? b_pip_r : b_lat_r);
	assign port_a_single_err = ~a_force & (oreg_on ? a_sep_r : a_se_r);
	assign port_a_double_err = ~a_force & (oreg_on ? a_dep_r : a_de_r);
	assign port_b_single_err = ~b_force & (oreg_on ? b_sep_r : b_se_r);
	assign port_b_double_err = ~b_force & (oreg_on ? b_dep_r : b_de_r);

	assign fifo_full = is_fifo & full_w;
	assign fifo_empty = ~is_fifo | empty_w;
	assign fifo_almost_full = is_fifo & (count >= af_level_r);
	assign fifo_almost_empty = ~is_fifo | (count <= ae_level_r);

	assign prdata = prdata_r;
	assign pready = psel & penable;
	assign pslverr = psel & penable & ~hit;

endmodule

// ---- dv/ebmf_assertions.sv ----
// Checker of the block memory port, reset and flag relations.
module ebmf_checker (
	input wire        clock,
	input wire        reset,
	input wire        global_reset_n,
	input wire        psel,
	input wire        penable,
	input wire        pready,
	input wire        pslverr,
	input wire        port_a_ce,
	input wire        port_a_output_reset,
	input wire [35:0] port_a_rdata,
	input wire        port_a_single_err,
	input wire        port_a_double_err,
	input wire        port_b_output_reset,
	input wire [35:0] port_b_rdata,
	input wire        port_b_single_err,
	input wire        port_b_double_err,
	input wire        fifo_full,
	input wire        fifo_empty,
	input wire        fifo_almost_empty
);
	timeunit 1ns;
	timeprecision 100ps;
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (reset);

	a_apb_zero_wait: assert property (psel && penable |-> pready)
		else $error("pready low in access phase");
	a_slverr_in_access: assert property (pslverr |-> psel && penable)
		else $error("pslverr outside access phase");
	a_porta_rst_clear: assert property (port_a_output_reset |=>
		port_a_rdata == 36'h0 && !port_a_single_err && !port_a_double_err)
		else $error("port a output reset left data or flags");
	a_portb_rst_clear: assert property (port_b_output_reset |=>
		port_b_rdata == 36'h0 && !port_b_single_err && !port_b_double_err)
		else $error("port b output reset left data or flags");
	a_global_rst_both: assert property (!global_reset_n [*4] |->
		port_a_rdata == 36'h0 && port_b_rdata == 36'h0)
		else $error("global reset did not clear both ports");
	a_err_flags_a: assert property (
		port_a_single_err |-> !port_a_double_err)
		else $error("port a single and double error together");
	a_err_flags_b: assert property (
		port_b_single_err |-> !port_b_double_err)
		else $error("port b single and double error together");
	a_err_after_read: assert property (port_a_single_err |->
		$past(port_a_ce, 2) || $past(port_a_ce, 3))
		else $error("port a error flag without a read");
	a_empty_is_low: assert property (
		fifo_empty |-> fifo_almost_empty)
		else $error("empty without almost empty");
	a_full_not_empty: assert property (
		fifo_full |-> !fifo_empty)
		else $error("full and empty together");
endmodule

bind ebmf_core ebmf_checker u_chk (
	.clock, .reset, .global_reset_n, .psel, .penable, .pready, .pslverr,
	.port_a_ce, .port_a_output_reset, .port_a_rdata, .port_a_single_err,
	.port_a_double_err, .port_b_output_reset, .port_b_rdata,
	.port_b_single_err, .port_b_double_err, .fifo_full, .fifo_empty,
	.fifo_almost_empty
);

// ---- dv/ebmf_fabric.sv ----
// Fabric-side model that drives the two memory ports.
module ebmf_fabric (
	input  wire         clock,
	output logic [1:0]  ce,
	output logic [1:0]  we,
	output logic [27:0] addr,
	output logic [71:0] wdata,
	output logic [7:0]  be,
	output logic [1:0]  orst
);
	timeunit 1ns;
	timeprecision 100ps;

	initial begin
		ce = 2'h0;
		we = 2'h0;
		addr = 28'h0;
		wdata = 72'h0;
		be = 8'h0;
		orst = 2'h0;
	end

	// One access on port p, held until the edge that takes it.
	task automatic cyc(input int p, input bit w, input [13:0] ad,
			input [35:0] d, input [3:0] b);
		@(posedge clock);
		ce[p] <= 1'b1;
		we[p] <= w;
		addr[p*14 +: 14] <= ad;
		wdata[p*36 +: 36] <= d;
		be[p*4 +: 4] <= b;
		@(posedge clock);
		ce <= 2'h0;
		we <= 2'h0;
		addr <= ~addr;
		wdata <= ~wdata;
	endtask

	// Each port's output reset is pulsed on its own.
	task automatic pulse_rst(input int p);
		@(posedge clock);
		orst[p] <= 1'b1;
		@(posedge clock);
		orst <= 2'h0;
	endtask
endmodule

// ---- dv/tb_embedded_block_ram_ecc_fifo.sv ----
// Self-checking bench of the embedded block memory.
`include "ebmf_defines.vh"
module tb_embedded_block_ram_ecc_fifo;
	timeunit 1ns;
	timeprecision 100ps;
	logic        clock, reset, global_reset_n, psel, penable, pwrite;
	logic        pready, pslverr, e, port_a_single_err, port_a_double_err;
	logic        port_b_single_err, port_b_double_err, fifo_full;
	logic        fifo_almost_full, fifo_empty, fifo_almost_empty;
	logic [7:0]  paddr, be;
	logic [31:0] pwdata, prdata, q;
	logic [1:0]  ce, we, orst;
	logic [27:0] addr;
	logic [71:0] wdata;
	logic [35:0] port_a_rdata, port_b_rdata, d, dm;
	logic [13:0] ad;
	logic [35:0] fq[$];
	int          err_count, total_checks, seed;
	localparam logic [7:0] roff [0:4] = '{`EBMF_OFF_CTRL, `EBMF_OFF_AF_LEVEL,
		`EBMF_OFF_AE_LEVEL, `EBMF_OFF_STATUS, `EBMF_OFF_INIT_HI};
	localparam logic [31:0] rexp [0:4] = '{32'h0, 32'h3f00, 32'h10,
		32'h3, 32'h0};

	ebmf_fabric u_fab (.clock, .ce, .we, .addr, .wdata, .be, .orst);
	ebmf_core u_dut (
		.clock, .reset, .global_reset_n, .paddr, .psel, .penable, .pwrite,
		.pwdata, .prdata, .pready, .pslverr,
		.port_a_ce(ce[0]), .port_a_we(we[0]), .port_a_addr(addr[13:0]),
		.port_a_wdata(wdata[35:0]), .port_a_byte_en(be[3:0]),
		.port_a_output_reset(orst[0]), .port_a_rdata, .port_a_single_err,
		.port_a_double_err, .port_b_ce(ce[1]), .port_b_we(we[1]),
		.port_b_addr(addr[27:14]), .port_b_wdata(wdata[71:36]),
		.port_b_byte_en(be[7:4]), .port_b_output_reset(orst[1]),
		.port_b_rdata, .port_b_single_err, .port_b_double_err, .fifo_full,
		.fifo_almost_full, .fifo_empty, .fifo_almost_empty
	);

	initial begin
		clock = 1'b0;
		forever #12.5 clock = ~clock;
	end

	function automatic logic [31:0] ctrl(input [2:0] m, input [2:0] w,
			input bit ecc);
		return {22'h0, ecc, w, w, m};
	endfunction

	function automatic int depth(input int wc);
		return 16384 >> wc;
	endfunction

	function automatic logic [35:0] flip(input int k);
		int b;
		b = $unsigned($random(seed)) % 31;
		return (k != 0) ? (36'h3 << b) : (36'h1 << b);
	endfunction

	// Gathers the four buffer flags as full, almost full, empty, almost empty.
	function automatic logic [35:0] fl();
		return {32'h0, fifo_full, fifo_almost_full, fifo_empty,
			fifo_almost_empty};
	endfunction

	task automatic chk(input logic [35:0] got, input logic [35:0] exp);
		total_checks++;
		if (got !== exp) begin
			err_count++;
			$display("BAD at %0t got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic apb(input bit w, input [7:0] a, input [31:0] dt);
		@(posedge clock);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= dt;
		@(posedge clock);
		penable <= 1'b1;
		@(posedge clock);
		while (pready !== 1'b1) @(posedge clock);
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic rd(input int p, input [13:0] a);
		u_fab.cyc(p, 1'b0, a, 36'h0, 4'hf);
		@(posedge clock);
		#1;
	endtask

	task automatic test_done();
		$display("checks %0d mismatches %0d", total_checks, err_count);
		if (err_count == 0 && total_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	initial begin
		repeat (10000) @(posedge clock);
		err_count++;
		test_done();
	end

	initial begin
		seed = 32'hf2457053;
		reset = 1'b1;
		global_reset_n = 1'b1;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h0;
		pwdata = 32'h0;
		repeat (6) @(posedge clock);
		reset <= 1'b0;
		foreach (roff[i]) begin
			apb(1'b0, roff[i], 32'h0);
			chk(36'(q), 36'(rexp[i]));
		end
		apb(1'b0, 8'h1c, 32'h0);
		chk({e, q}, 36'h100000000);
		$display("test registers done");
		apb(1'b1, `EBMF_OFF_CTRL, ctrl(3'h0, 3'h5, 1'b0));
		repeat (8) begin
			ad = 14'($unsigned($random(seed)) % 512);
			d = {4'($random(seed)), 32'($random(seed))};
			u_fab.cyc(0, 1'b1, ad, d, 4'hf);
			rd(0, ad);
			chk(port_a_rdata, d);
		end
		u_fab.cyc(0, 1'b1, ad, ~d, 4'h1);
		dm = {d[35:9], ~d[8:0]};
		rd(0, ad);
		chk(port_a_rdata, dm);
		apb(1'b1, `EBMF_OFF_CTRL, ctrl(3'h3, 3'h5, 1'b0));
		u_fab.cyc(0, 1'b1, ad, 36'h0, 4'hf);
		rd(1, ad);
		chk(port_b_rdata, dm);
		chk({port_b_double_err, port_b_single_err}, 36'h0);
		rd(0, ad);
		chk(port_a_rdata, dm);
		u_fab.pulse_rst(0);
		#1;
		chk(port_a_rdata, 36'h0);
		chk(port_b_rdata, dm);
		@(posedge clock);
		global_reset_n <= 1'b0;
		repeat (4) @(posedge clock);
		#1;
		chk(port_b_rdata, 36'h0);
		@(posedge clock);
		global_reset_n <= 1'b1;
		repeat (3) @(posedge clock);
		$display("test ports done");
		for (int k = 0; k < 2; k++) begin
			d = {4'h0, 32'($random(seed))};
			apb(1'b1, `EBMF_OFF_CTRL, ctrl(3'h0, 3'h5, 1'b1));
			u_fab.cyc(0, 1'b1, 14'h7, d, 4'hf);
			apb(1'b1, `EBMF_OFF_CTRL, ctrl(3'h0, 3'h5, 1'b0));
			u_fab.cyc(0, 1'b1, 14'h7, d ^ flip(k), 4'hf);
			apb(1'b1, `EBMF_OFF_CTRL, ctrl(3'h0, 3'h5, 1'b1));
			rd(0, 14'h7);
			if (k == 0) chk(port_a_rdata, d);
			chk({port_a_double_err, port_a_single_err}, k + 1);
		end
		apb(1'b0, `EBMF_OFF_STATUS, 32'h0);
		chk(36'(q[5:4]), 36'h3);
		$display("test ecc done");
		apb(1'b1, `EBMF_OFF_AF_LEVEL, 32'd510);
		apb(1'b1, `EBMF_OFF_CTRL, ctrl(3'h4, 3'h5, 1'b0));
		for (int i = 0; i <= depth(5); i++) begin
			d = {4'($random(seed)), 32'($random(seed))};
			if (i < depth(5)) fq.push_back(d);
			u_fab.cyc(0, 1'b1, 14'h0, d, 4'hf);
		end
		repeat (2) @(posedge clock);
		#1;
		chk(fl(), 36'hc);
		while (fq.size() > 0) begin
			rd(1, 14'h0);
			chk(port_b_rdata, fq.pop_front());
		end
		repeat (2) @(posedge clock);
		#1;
		chk(fl(), 36'h3);
		$display("test fifo done");
		apb(1'b1, `EBMF_OFF_CTRL, ctrl(3'h0, 3'h5, 1'b0) | 32'hc00);
		d = {4'($random(seed)), 32'($random(seed))};
		u_fab.cyc(0, 1'b1, 14'h7, 36'h0, 4'hf);
		u_fab.cyc(0, 1'b1, 14'h9, d, 4'hf);
		u_fab.pulse_rst(0);
		rd(0, 14'h9);
		chk(port_a_rdata, 36'h0);
		@(posedge clock);
		#1;
		chk(port_a_rdata, d);
		fork
			u_fab.pulse_rst(0);
			begin
				@(posedge clock);
				#1;
				chk(port_a_rdata, 36'h0);
			end
		join
		apb(1'b1, `EBMF_OFF_CTRL, ctrl(3'h0, 3'h5, 1'b0) | 32'h400);
		rd(0, 14'h9);
		@(posedge clock);
		#1;
		chk(port_a_rdata, d);
		u_fab.pulse_rst(0);
		#1;
		chk(port_a_rdata, 36'h0);
		apb(1'b1, `EBMF_OFF_CTRL, {23'h0, 3'h5, 3'h0, 3'h2});
		u_fab.cyc(0, 1'b1, 14'he5, 36'h1, 4'hf);
		rd(1, 14'h7);
		chk(port_b_rdata, 36'h20);
		$display("test options done");
		test_done();
	end
endmodule
